// ===== hdl/ita_defines.vh
// constants for the ignition timing adjustment block
//
// Behaviour
// RL1: left and right knob stops accept 0.00 to 58.00 degrees, hundredths resolution.
// RL2: knob stops accept advance values only; retard values are rejected.
// RL3: knob term enters the sum only while knob_enable is set.
// RL4: one knob span serves both schedules.
// RL5: summed timing saturates at the active schedule's earliest and latest limits.
// RL6: separate limits per schedule; schedule B limits writable only in A/B mode.
// RL7: reject limits whose earliest-to-latest distance exceeds 38 degrees.
// RL8: earliest limit must lie at least 2 degrees later than home position.
// RL9: reject latest limit more than 40 degrees later than home position.
// RL10: earliest not later than latest; no limit after top dead centre.
// RL11: schedule B active adds signed offset up to 40.00 degrees.
// RL12: schedule B offset writable and used only in A/B switch mode.
// RL13: loop angles writable only when loop is enabled in some schedule.
// RL14: loop term interpolates linearly from 4 mA angle toward 20 mA angle.
// RL15: missing loop signal or below 4 mA uses the fallback angle.
// RL16: loop endpoints within 40 degrees each and differ by 40 at most.
// RL17: curve point count 0 to 5; only that many breakpoints writable.
// RL18: point count zero means no speed curve contribution.
// RL19: breakpoint holds speed 0 to 5000 rpm and angle up to 40.00.
// RL20: curve applies in schedule B only when input does schedule switching.
// RL21: knob disabled gives zero knob term, ignoring the stop values.
// RL22: per-schedule enables for curve and loop gate each term.
// RL23: total is knob plus loop plus curve plus B offset, then limited.
// RL24: curve interpolates between breakpoints, holds last angle beyond it.
`ifndef ITA_DEFINES_VH
`define ITA_DEFINES_VH
// ==========================================
// register offsets
`define ITA_REG_CTRL 8'h00
`define ITA_REG_HOME 8'h04
`define ITA_REG_LEFT 8'h08
`define ITA_REG_RIGHT 8'h0C
`define ITA_REG_LIM_A 8'h10
`define ITA_REG_LIM_B 8'h14
`define ITA_REG_OFFSET 8'h18
`define ITA_REG_LOOP_LO 8'h1C
`define ITA_REG_LOOP_HI 8'h20
`define ITA_REG_LOOP_FB 8'h24
`define ITA_REG_BP0 8'h28
`define ITA_REG_BP4 8'h38
`define ITA_REG_STATUS 8'h40
`define ITA_REG_RESULT 8'h44
// ==========================================
// control field positions
`define ITA_CTRL_KNOB 0
`define ITA_CTRL_AB 1
`define ITA_CTRL_CURVE_A 2
`define ITA_CTRL_CURVE_B 3
`define ITA_CTRL_LOOP_A 4
`define ITA_CTRL_LOOP_B 5
`define ITA_CTRL_NPTS_LO 8
`define ITA_CTRL_NPTS_HI 10
// ==========================================
// value ranges; angles in hundredths of a degree, advance positive, speed in rpm
`define ITA_STOP_MAX 18'h016A8
`define ITA_SPAN_MAX 18'h00ED8
`define ITA_HOME_GAP 18'h000C8
`define ITA_ANG_MAX 18'h00FA0
`define ITA_RPM_MAX 13'h1388
`define ITA_NPTS_MAX 3'h5
// loop level code: 4 mA and 20 mA, span is 2^12
`define ITA_LOOP_4MA 13'h0400
`define ITA_LOOP_20MA 13'h1400
`define ITA_LOOP_SPAN 13'h1000
`define ITA_DIV_STEPS 5'h1B
// ==========================================
// reset values
`define ITA_RST_CTRL 11'h001
`define ITA_RST_HOME 16'h0BB8
`define ITA_RST_EARLY 16'h09C4
`define ITA_RST_LATE 16'h01F4
`endif

// ===== hdl/ita_timing_adjust.v
// ignition timing adjustment: settings, term sum and limiting
//
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`include "ita_defines.vh"

module ita_timing_adjust (
    input wire REF_CLK,
    input wire SYS_RST,
    input wire [7:0] REG_ADDR,
    input wire [31:0] REG_WDATA,
    input wire REG_WR,
    input wire REG_RD,
    output wire [31:0] REG_RDATA,
    input wire [9:0] KNOB_POS,
    input wire [12:0] LOOP_LEVEL,
    input wire LOOP_PRESENT,
    input wire [12:0] ENGINE_RPM,
    input wire SWITCH_CLOSED,
    output wire [15:0] TIMING_ANGLE,
    output wire SCHED_B_ACTIVE
);

    localparam ST_IDLE = 1'b0;
    localparam ST_DIV = 1'b1;

    // ==========================================
    // helpers
    function [17:0] sx;
        input [15:0] v;
        begin
            sx = {{2{v[15]}}, v};
        end
    endfunction

    function in_rng;
        input signed [17:0] v;
        input signed [17:0] lo;
        input signed [17:0] hi;
        begin
            in_rng = (v >= lo) && (v <= hi);
        end
    endfunction

    // ==========================================
    // pin synchronisers, two stages; multi-bit buses are slow sensor values
    reg [9:0] pos_m_q, pos_q;
    reg [12:0] lvl_m_q, lvl_q, rpm_m_q, rpm_q;
    reg pres_m_q, pres_q, sw_m_q, sw_q;

    always @(posedge REF_CLK)
    begin
        if (SYS_RST)
        begin
            pos_m_q <= 10'h000;
            pos_q <= 10'h000;
            lvl_m_q <= 13'h0000;
            lvl_q <= 13'h0000;
            rpm_m_q <= 13'h0000;
            rpm_q <= 13'h0000;
            pres_m_q <= 1'b0;
            pres_q <= 1'b0;
            sw_m_q <= 1'b0;
            sw_q <= 1'b0;
        end
        else
        begin
            pos_m_q <= KNOB_POS;
            pos_q <= pos_m_q;
            lvl_m_q <= LOOP_LEVEL;
            lvl_q <= lvl_m_q;
            rpm_m_q <= ENGINE_RPM;
            rpm_q <= rpm_m_q;
            pres_m_q <= LOOP_PRESENT;
            pres_q <= pres_m_q;
            sw_m_q <= SWITCH_CLOSED;
            sw_q <= sw_m_q;
        end
    end

    // ==========================================
    // settings
    reg [10:0] ctrl_q;
    reg [15:0] home_q, left_q, right_q, ea_q, la_q, eb_q, lb_q;
    reg [15:0] off_q, lo_q, hi_q, fb_q;
    reg [12:0] bp_spd_q [0:4];
    reg [15:0] bp_ang_q [0:4];
    reg rej_q;
    reg [31:0] rdata_q;
    reg signed [15:0] curve_q;
    reg signed [15:0] timing_q;
    reg fb_use_q;

    wire knob_en = ctrl_q[`ITA_CTRL_KNOB];
    wire ab_fn = ctrl_q[`ITA_CTRL_AB];
    wire [2:0] npts = ctrl_q[`ITA_CTRL_NPTS_HI:`ITA_CTRL_NPTS_LO];
    // A/B switch mode off keeps the block on schedule A whatever the pin does
    wire sched_b = ab_fn & sw_q;

    wire signed [17:0] w_lo = sx(REG_WDATA[15:0]);
    wire signed [17:0] w_hi = sx(REG_WDATA[31:16]);
    wire signed [17:0] home_s = sx(home_q);
    wire [7:0] bp_off = REG_ADDR - `ITA_REG_BP0;
    wire [2:0] bp_idx = bp_off[4:2];
    wire bp_hit = (REG_ADDR >= `ITA_REG_BP0) && (REG_ADDR <= `ITA_REG_BP4) &&
                  (REG_ADDR[1:0] == 2'h0);

    // ==========================================
    // write checking
    reg wr_ok;
    reg wr_map;

    always @*
    begin
        wr_ok = 1'b0;
        wr_map = 1'b1;
        if (REG_ADDR == `ITA_REG_CTRL)
            wr_ok = (REG_WDATA[`ITA_CTRL_NPTS_HI:`ITA_CTRL_NPTS_LO] <= `ITA_NPTS_MAX);
        else if (REG_ADDR == `ITA_REG_HOME)
            wr_ok = ~REG_WDATA[15];
        // RL1 RL2 stop range
        else if ((REG_ADDR == `ITA_REG_LEFT) || (REG_ADDR == `ITA_REG_RIGHT))
            wr_ok = in_rng(w_lo, 18'h00000, `ITA_STOP_MAX);
        // RL6 RL7 RL8 RL9 RL10 limit checks
        else if ((REG_ADDR == `ITA_REG_LIM_A) || (REG_ADDR == `ITA_REG_LIM_B))
            wr_ok = ((REG_ADDR == `ITA_REG_LIM_A) || ab_fn) &&
                    in_rng(w_lo, 18'h00000, w_hi) &&
                    in_rng(w_hi - w_lo, 18'h00000, `ITA_SPAN_MAX) &&
                    (w_hi <= $signed(home_s - `ITA_HOME_GAP)) &&
                    (w_lo >= $signed(home_s - `ITA_ANG_MAX));
        // RL12 offset gated by switch mode
        else if (REG_ADDR == `ITA_REG_OFFSET)
            wr_ok = ab_fn && in_rng(w_lo, -`ITA_ANG_MAX, `ITA_ANG_MAX);
        // RL13 RL16 loop endpoints
        else if (REG_ADDR == `ITA_REG_LOOP_LO)
            wr_ok = (ctrl_q[`ITA_CTRL_LOOP_A] | ctrl_q[`ITA_CTRL_LOOP_B]) &&
                    in_rng(w_lo, -`ITA_ANG_MAX, `ITA_ANG_MAX) &&
                    in_rng(w_lo - sx(hi_q), -`ITA_ANG_MAX, `ITA_ANG_MAX);
        else if (REG_ADDR == `ITA_REG_LOOP_HI)
            wr_ok = (ctrl_q[`ITA_CTRL_LOOP_A] | ctrl_q[`ITA_CTRL_LOOP_B]) &&
                    in_rng(w_lo, -`ITA_ANG_MAX, `ITA_ANG_MAX) &&
                    in_rng(w_lo - sx(lo_q), -`ITA_ANG_MAX, `ITA_ANG_MAX);
        else if (REG_ADDR == `ITA_REG_LOOP_FB)
            wr_ok = (ctrl_q[`ITA_CTRL_LOOP_A] | ctrl_q[`ITA_CTRL_LOOP_B]) &&
                    in_rng(w_lo, -`ITA_ANG_MAX, `ITA_ANG_MAX);
        // RL17 RL19 breakpoint index and ranges
        else if (bp_hit)
            wr_ok = (bp_idx < npts) && (REG_WDATA[28:16] <= `ITA_RPM_MAX) &&
                    in_rng(w_lo, -`ITA_ANG_MAX, `ITA_ANG_MAX);
        else if ((REG_ADDR == `ITA_REG_STATUS) || (REG_ADDR == `ITA_REG_RESULT))
            wr_ok = 1'b0;
        else
            wr_map = 1'b0;
    end

    integer k;

    always @(posedge REF_CLK)
    begin
        if (SYS_RST)
        begin
            ctrl_q <= `ITA_RST_CTRL;
            home_q <= `ITA_RST_HOME;
            left_q <= 16'h0000;
            right_q <= 16'h0000;
            ea_q <= `ITA_RST_EARLY;
            la_q <= `ITA_RST_LATE;
            eb_q <= `ITA_RST_EARLY;
            lb_q <= `ITA_RST_LATE;
            off_q <= 16'h0000;
            lo_q <= 16'h0000;
            hi_q <= 16'h0000;
            fb_q <= 16'h0000;
            rej_q <= 1'b0;
            for (k = 0; k < 5; k = k + 1)
            begin
                bp_spd_q[k] <= 13'h0000;
                bp_ang_q[k] <= 16'h0000;
            end
        end
        else if (REG_WR && wr_map)
        begin
            // a refused write leaves every setting unchanged
            rej_q <= ~wr_ok;
            if (wr_ok)
            begin
                if (REG_ADDR == `ITA_REG_CTRL)
                    ctrl_q <= REG_WDATA[10:0];
                else if (REG_ADDR == `ITA_REG_HOME)
                    home_q <= REG_WDATA[15:0];
                else if (REG_ADDR == `ITA_REG_LEFT)
                    left_q <= REG_WDATA[15:0];
                else if (REG_ADDR == `ITA_REG_RIGHT)
                    right_q <= REG_WDATA[15:0];
                else if (REG_ADDR == `ITA_REG_LIM_A)
                begin
                    ea_q <= REG_WDATA[31:16];
                    la_q <= REG_WDATA[15:0];
                end
                else if (REG_ADDR == `ITA_REG_LIM_B)
                begin
                    eb_q <= REG_WDATA[31:16];
                    lb_q <= REG_WDATA[15:0];
                end
                else if (REG_ADDR == `ITA_REG_OFFSET)
                    off_q <= REG_WDATA[15:0];
                else if (REG_ADDR == `ITA_REG_LOOP_LO)
                    lo_q <= REG_WDATA[15:0];
                else if (REG_ADDR == `ITA_REG_LOOP_HI)
                    hi_q <= REG_WDATA[15:0];
                else if (REG_ADDR == `ITA_REG_LOOP_FB)
                    fb_q <= REG_WDATA[15:0];
                else if (bp_hit)
                begin
                    bp_spd_q[bp_idx] <= REG_WDATA[28:16];
                    bp_ang_q[bp_idx] <= REG_WDATA[15:0];
                end
            end
        end
    end

    // ==========================================
    // speed curve segment search
    reg seg_hold;
    reg [15:0] seg_a;
    reg signed [17:0] seg_d;
    reg [12:0] seg_dist;
    reg [12:0] seg_den;
    integer i;

    always @*
    begin
        seg_hold = 1'b1;
        seg_a = 16'h0000;
        seg_d = 18'h00000;
        seg_dist = 13'h0000;
        seg_den = 13'h0001;
        // RL18 no points, no curve
        if (npts == 3'h0)
            seg_a = 16'h0000;
        else if (rpm_q <= bp_spd_q[0])
            seg_a = bp_ang_q[0];
        else
        begin
            // RL24 hold last angle, interpolate inside a segment
            seg_a = bp_ang_q[npts - 3'h1];
            for (i = 0; i < 4; i = i + 1)
            begin
                if ((i + 1 < npts) && (rpm_q >= bp_spd_q[i]) && (rpm_q < bp_spd_q[i + 1]))
                begin
                    seg_hold = 1'b0;
                    seg_a = bp_ang_q[i];
                    seg_d = sx(bp_ang_q[i + 1]) - sx(bp_ang_q[i]);
                    seg_dist = rpm_q - bp_spd_q[i];
                    seg_den = bp_spd_q[i + 1] - bp_spd_q[i];
                end
            end
        end
    end

    // ==========================================
    // serial divider; one result every few dozen cycles is ample for rpm
    reg state_q;
    reg [26:0] quo_q;
    reg [13:0] rem_q;
    reg [12:0] den_q;
    reg [4:0] cnt_q;
    reg [15:0] base_q;
    reg neg_q;

    wire [17:0] seg_mag = seg_d[17] ? (18'h00000 - seg_d) : seg_d;
    wire [26:0] seg_num = seg_mag[13:0] * seg_dist;
    wire [13:0] rem_sh = {rem_q[12:0], quo_q[26]};
    wire rem_ge = (rem_sh >= {1'b0, den_q});
    wire [13:0] rem_sub = rem_sh - {1'b0, den_q};

    always @(posedge REF_CLK)
    begin
        if (SYS_RST)
        begin
            state_q <= ST_IDLE;
            quo_q <= 27'h0000000;
            rem_q <= 14'h0000;
            den_q <= 13'h0001;
            cnt_q <= 5'h00;
            base_q <= 16'h0000;
            neg_q <= 1'b0;
            curve_q <= 16'h0000;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    if (seg_hold)
                        curve_q <= seg_a;
                    else
                    begin
                        quo_q <= seg_num;
                        rem_q <= 14'h0000;
                        den_q <= seg_den;
                        cnt_q <= `ITA_DIV_STEPS;
                        base_q <= seg_a;
                        neg_q <= seg_d[17];
                        state_q <= ST_DIV;
                    end
                end
                ST_DIV:
                begin
                    if (cnt_q == 5'h00)
                    begin
                        curve_q <= neg_q ? (base_q - quo_q[15:0]) : (base_q + quo_q[15:0]);
                        state_q <= ST_IDLE;
                    end
                    else
                    begin
                        rem_q <= rem_ge ? rem_sub : rem_sh;
                        quo_q <= {quo_q[25:0], rem_ge};
                        cnt_q <= cnt_q - 5'h01;
                    end
                end
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    // ==========================================
    // knob and loop terms
    // RL4 one span for both schedules
    wire signed [17:0] knob_span = sx(right_q) - sx(left_q);
    wire signed [28:0] knob_prod = knob_span * $signed({1'b0, pos_q});
    // RL3 RL21 knob gated, zero when off
    wire signed [17:0] knob_term = knob_en ? (sx(left_q) + knob_prod[27:10]) : 18'h00000;

    // RL15 fallback when absent or under 4 mA
    wire loop_bad = ~pres_q | (lvl_q < `ITA_LOOP_4MA);
    wire [12:0] lvl_off = (lvl_q >= `ITA_LOOP_20MA) ? `ITA_LOOP_SPAN : (lvl_q - `ITA_LOOP_4MA);
    wire signed [17:0] loop_span = sx(hi_q) - sx(lo_q);
    wire signed [31:0] loop_prod = loop_span * $signed({1'b0, lvl_off});
    // RL14 linear toward the 20 mA angle
    wire signed [17:0] loop_val = loop_bad ? sx(fb_q) : (sx(lo_q) + loop_prod[29:12]);

    // RL22 RL20 per-schedule enables; B needs switch mode
    wire loop_on = sched_b ? ctrl_q[`ITA_CTRL_LOOP_B] : ctrl_q[`ITA_CTRL_LOOP_A];
    wire curve_on = sched_b ? ctrl_q[`ITA_CTRL_CURVE_B] : ctrl_q[`ITA_CTRL_CURVE_A];

    // ==========================================
    // sum and limit
    // RL23 sum of all terms
    // RL11 offset only while schedule B runs
    wire signed [17:0] total = knob_term + (loop_on ? loop_val : 18'h00000) +
                               (curve_on ? sx(curve_q) : 18'h00000) +
                               (sched_b ? sx(off_q) : 18'h00000);
    wire signed [17:0] lim_e = sched_b ? sx(eb_q) : sx(ea_q);
    wire signed [17:0] lim_l = sched_b ? sx(lb_q) : sx(la_q);

    always @(posedge REF_CLK)
    begin
        if (SYS_RST)
        begin
            timing_q <= `ITA_RST_LATE;
            fb_use_q <= 1'b0;
        end
        else
        begin
            fb_use_q <= loop_on & loop_bad;
            // RL5 saturate at active limits
            if (total > lim_e)
                timing_q <= lim_e[15:0];
            else if (total < lim_l)
                timing_q <= lim_l[15:0];
            else
                timing_q <= total[15:0];
        end
    end

    // ==========================================
    // read port, data valid only in the cycle after the strobe
    reg [31:0] rd_d;

    always @*
    begin
        rd_d = 32'h00000000;
        if (REG_ADDR == `ITA_REG_CTRL)
            rd_d = {21'h000000, ctrl_q};
        else if (REG_ADDR == `ITA_REG_HOME)
            rd_d = {16'h0000, home_q};
        else if (REG_ADDR == `ITA_REG_LEFT)
            rd_d = {16'h0000, left_q};
        else if (REG_ADDR == `ITA_REG_RIGHT)
            rd_d = {16'h0000, right_q};
        else if (REG_ADDR == `ITA_REG_LIM_A)
            rd_d = {ea_q, la_q};
        else if (REG_ADDR == `ITA_REG_LIM_B)
            rd_d = {eb_q, lb_q};
        else if (REG_ADDR == `ITA_REG_OFFSET)
            rd_d = {16'h0000, off_q};
        else if (REG_ADDR == `ITA_REG_LOOP_LO)
            rd_d = {16'h0000, lo_q};
        else if (REG_ADDR == `ITA_REG_LOOP_HI)
            rd_d = {16'h0000, hi_q};
        else if (REG_ADDR == `ITA_REG_LOOP_FB)
            rd_d = {16'h0000, fb_q};
        else if (bp_hit)
            rd_d = {3'h0, bp_spd_q[bp_idx], bp_ang_q[bp_idx]};
        else if (REG_ADDR == `ITA_REG_STATUS)
            rd_d = {28'h0000000, state_q, fb_use_q, sched_b, rej_q};
        else if (REG_ADDR == `ITA_REG_RESULT)
            rd_d = {16'h0000, timing_q};
    end

    always @(posedge REF_CLK)
    begin
        if (SYS_RST)
            rdata_q <= 32'h00000000;
        else
            rdata_q <= REG_RD ? rd_d : 32'h00000000;
    end

    assign REG_RDATA = rdata_q;
    assign TIMING_ANGLE = timing_q;
    assign SCHED_B_ACTIVE = sched_b;

endmodule // ita_timing_adjust

// ===== verification/ita_timing_adjust_properties.sv
// port assertions for the timing adjust block
`timescale 1ns/1ps
module ita_props (
    input wire REF_CLK,
    input wire SYS_RST,
    input wire [7:0] REG_ADDR,
    input wire [31:0] REG_WDATA,
    input wire REG_WR,
    input wire REG_RD,
    input wire [31:0] REG_RDATA,
    input wire [9:0] KNOB_POS,
    input wire [12:0] LOOP_LEVEL,
    input wire LOOP_PRESENT,
    input wire [12:0] ENGINE_RPM,
    input wire SWITCH_CLOSED,
    input wire [15:0] TIMING_ANGLE,
    input wire SCHED_B_ACTIVE
);
// ==========
// helpers
// widened so a far negative latest value cannot wrap the gap
wire signed [17:0] lim_gap = $signed({{2{REG_WDATA[31]}}, REG_WDATA[31:16]})
    - $signed({{2{REG_WDATA[15]}}, REG_WDATA[15:0]});
default clocking cb @(posedge REF_CLK); endclocking
default disable iff (SYS_RST);
sequence s_stat;
    REG_RD && REG_ADDR == 8'h40;
endsequence
// ==========
// properties
property p_result;
    REG_RD && REG_ADDR == 8'h44 |=> REG_RDATA[15:0] == $past(TIMING_ANGLE);
endproperty
a_result: assert property (p_result) else $error("result read differs");
property p_stat_b;
    s_stat |=> REG_RDATA[1] == $past(SCHED_B_ACTIVE);
endproperty
a_stat_b: assert property (p_stat_b) else $error("status b flag differs");
property p_b_sync;
    SCHED_B_ACTIVE |-> $past(SWITCH_CLOSED, 2);
endproperty
a_b_sync: assert property (p_b_sync) else $error("schedule b without switch");
property p_no_atdc;
    !TIMING_ANGLE[15];
endproperty
a_no_atdc: assert property (p_no_atdc) else $error("timing after tdc");
property p_rst_val;
    $fell(SYS_RST) |-> TIMING_ANGLE == 16'h01F4;
endproperty
a_rst_val: assert property (p_rst_val) else $error("timing not at latest limit");
property p_rej_stop;
    REG_WR && (REG_ADDR == 8'h08 || REG_ADDR == 8'h0C) && REG_WDATA[15:0] > 16'h16A8
        ##1 s_stat |=> REG_RDATA[0];
endproperty
a_rej_stop: assert property (p_rej_stop) else $error("bad stop taken");
property p_rej_lim;
    REG_WR && REG_ADDR == 8'h10 && lim_gap > 3800 ##1 s_stat |=> REG_RDATA[0];
endproperty
a_rej_lim: assert property (p_rej_lim) else $error("wide limits taken");
property p_rej_npts;
    REG_WR && REG_ADDR == 8'h00 && REG_WDATA[10:8] > 3'h5 ##1 s_stat |=> REG_RDATA[0];
endproperty
a_rej_npts: assert property (p_rej_npts) else $error("point count taken");
endmodule // ita_props
bind ita_timing_adjust ita_props u_props (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .KNOB_POS(KNOB_POS), .LOOP_LEVEL(LOOP_LEVEL),
    .LOOP_PRESENT(LOOP_PRESENT), .ENGINE_RPM(ENGINE_RPM), .SWITCH_CLOSED(SWITCH_CLOSED),
    .TIMING_ANGLE(TIMING_ANGLE), .SCHED_B_ACTIVE(SCHED_B_ACTIVE));

// ===== verification/ita_sensor_model.sv
// sensor side model: knob, current loop, speed and switch pins
`timescale 1ns/1ps
module ita_sensor_model (
    input wire clk,
    input wire [9:0] knob_set,
    input wire [12:0] level_set,
    input wire present_set,
    input wire [12:0] rpm_set,
    input wire switch_set,
    output reg [9:0] knob_pos = 10'h000,
    output reg [12:0] loop_level = 13'h0000,
    output reg loop_present = 1'b0,
    output reg [12:0] engine_rpm = 13'h0000,
    output reg switch_closed = 1'b0
);
// ==========
// pins
// a broken loop wire flips every bit each cycle, never reading as its last value
always @(posedge clk)
begin
    knob_pos <= knob_set;
    loop_level <= present_set ? level_set : ~loop_level;
    loop_present <= present_set;
    engine_rpm <= rpm_set;
    switch_closed <= switch_set;
end
endmodule // ita_sensor_model

// ===== verification/test_ita_timing_adjust.sv
// self-checking bench for the timing adjust block
`timescale 1ns/1ps
module test_ita_timing_adjust;
reg clk = 1'b0;
reg rst = 1'b1;
reg [7:0] addr = 8'h00;
reg [31:0] wdata = 32'h0;
reg wr = 1'b0;
reg rd = 1'b0;
wire [31:0] rdata;
reg [9:0] k_set = 10'h000;
reg [12:0] l_set = 13'h0000;
reg p_set = 1'b0;
reg [12:0] r_set = 13'h0000;
reg s_set = 1'b0;
wire [9:0] knob;
wire [12:0] lvl;
wire pres;
wire [12:0] rpm;
wire sw;
wire [15:0] ang;
wire schb;
integer n_mismatch = 0;
integer n_tests = 0;
integer i;
reg [31:0] v;
reg [10:0] c;
reg [15:0] e;
reg [40:0] tab [0:29];
ita_timing_adjust uut (.REF_CLK(clk), .SYS_RST(rst), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .KNOB_POS(knob), .LOOP_LEVEL(lvl),
    .LOOP_PRESENT(pres), .ENGINE_RPM(rpm), .SWITCH_CLOSED(sw), .TIMING_ANGLE(ang),
    .SCHED_B_ACTIVE(schb));
ita_sensor_model u_sens (.clk(clk), .knob_set(k_set), .level_set(l_set),
    .present_set(p_set), .rpm_set(r_set), .switch_set(s_set), .knob_pos(knob),
    .loop_level(lvl), .loop_present(pres), .engine_rpm(rpm), .switch_closed(sw));
// ==========
// tasks, entered just after a clock edge
task wr_reg(input [7:0] a, input [31:0] d);
begin
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
end
endtask
task rd_reg(input [7:0] a, output [31:0] d);
begin
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    d = rdata;
end
endtask
task chk(input [31:0] ex, input [31:0] got, input string nm);
begin
    n_tests = n_tests + 1;
    if (got !== ex)
    begin
        $display("[ERR] %0s expected %h seen %h", nm, ex, got);
        n_mismatch = n_mismatch + 1;
    end
end
endtask
task end_of_test;
begin
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
        $display("bench passed");
    else
        $display("bench failed");
    $finish;
end
endtask
// ==========
// expected angle; settings fixed by the table below
function integer exp_ang(input [10:0] cc, input s, input [9:0] k, input [12:0] lv,
    input pr, input [12:0] r);
    integer t, b, lp, cv, d, li, ri;
    begin
        li = lv;
        ri = r;
        b = cc[1] & s;
        t = cc[0] ? (5800 * k) >>> 10 : 0;
        d = (li > 5120) ? 4096 : li - 1024;
        lp = (!pr || li < 1024) ? -400 : -4000 + ((4000 * d) >>> 12);
        if (ri < 50)
            cv = (-1000 * ri) / 50;
        else if (ri < 1000)
            cv = -1000 + (1000 * (ri - 50)) / 950;
        else
            cv = 0;
        if (cc[10:8] == 3'h0)
            cv = 0;
        if (cc[b ? 5 : 4])
            t = t + lp;
        if (cc[b ? 3 : 2])
            t = t + cv;
        if (b)
            t = t - 200;
        d = b ? 4500 : 4800;
        li = b ? 1500 : 1000;
        exp_ang = (t > d) ? d : ((t < li) ? li : t);
    end
endfunction
// ==========
// clock, watchdog
initial
begin
    forever #2 clk = ~clk;
end
initial
begin
    #100000;
    n_mismatch = n_mismatch + 1;
    end_of_test;
end
// ==========
// main sequence
initial
begin
    v = $urandom(53401);
    tab[0] = {1'b1, 8'h08, 32'h000016A9};
    tab[1] = {1'b1, 8'h08, 32'h0000FFFF};
    tab[2] = {1'b0, 8'h0C, 32'h000016A8};
    tab[3] = {1'b1, 8'h14, 32'h09C401F4};
    tab[4] = {1'b1, 8'h18, 32'h00000064};
    tab[5] = {1'b1, 8'h1C, 32'h00000064};
    tab[6] = {1'b1, 8'h00, 32'h00000600};
    tab[7] = {1'b1, 8'h10, 32'h07D0FF9C};
    tab[8] = {1'b1, 8'h10, 32'h03E803E9};
    tab[9] = {1'b0, 8'h00, 32'h0000033F};
    tab[10] = {1'b1, 8'h34, 32'h00000000};
    tab[11] = {1'b1, 8'h28, 32'h13890000};
    tab[12] = {1'b0, 8'h04, 32'h00001388};
    tab[13] = {1'b1, 8'h10, 32'h12C103E8};
    tab[14] = {1'b1, 8'h10, 32'h0FA003E7};
    tab[15] = {1'b1, 8'h10, 32'h12C003E7};
    tab[16] = {1'b0, 8'h10, 32'h12C003E8};
    tab[17] = {1'b0, 8'h14, 32'h119405DC};
    tab[18] = {1'b1, 8'h18, 32'h00000FA1};
    tab[19] = {1'b0, 8'h18, 32'h0000FF38};
    tab[20] = {1'b1, 8'h1C, 32'h00000FA1};
    tab[21] = {1'b0, 8'h1C, 32'h0000F060};
    tab[22] = {1'b1, 8'h20, 32'h00000064};
    tab[23] = {1'b0, 8'h20, 32'h00000000};
    tab[24] = {1'b0, 8'h24, 32'h0000FE70};
    tab[25] = {1'b0, 8'h28, 32'h00000000};
    tab[26] = {1'b0, 8'h2C, 32'h0032FC18};
    tab[27] = {1'b0, 8'h30, 32'h03E80000};
    tab[28] = {1'b1, 8'h40, 32'h00000000};
    tab[29] = {1'b1, 8'h80, 32'h00000000};
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    rd_reg(8'h00, v);
    chk(32'h00000001, v, "ctrl");
    rd_reg(8'h04, v);
    chk(32'h00000BB8, v, "home");
    rd_reg(8'h10, v);
    chk(32'h09C401F4, v, "lim_a");
    rd_reg(8'h14, v);
    chk(32'h09C401F4, v, "lim_b");
    rd_reg(8'h80, v);
    chk(32'h00000000, v, "unmapped");
    rd_reg(8'h44, v);
    chk(32'h000001F4, v, "result");
    // refusal then status read, back to back
    for (i = 0; i < 30; i = i + 1)
    begin
        wr_reg(tab[i][39:32], tab[i][31:0]);
        rd_reg(8'h40, v);
        chk({31'h0, tab[i][40]}, {31'h0, v[0]}, "reject");
    end
    // random timing, loop corners at 4 mA and 20 mA first
    for (i = 0; i < 60; i = i + 1)
    begin
        c = {($urandom % 2) ? 3'h3 : 3'h0, 2'h0, 6'($urandom)};
        wr_reg(8'h00, {21'h0, c});
        k_set <= $urandom % 1024;
        l_set <= (i == 0) ? 13'h03FF : (i == 1) ? 13'h0400 : (i == 2) ? 13'h1400 : $urandom % 6000;
        p_set <= (i < 3) ? 1'b1 : 1'($urandom);
        r_set <= $urandom % 1500;
        s_set <= $urandom;
        // a divider run on stale pins can delay the new curve by one run
        repeat (70) @(posedge clk);
        e = exp_ang(c, s_set, k_set, l_set, p_set, r_set);
        chk({16'h0, e}, {16'h0, ang}, "angle");
        chk({31'h0, c[1] & s_set}, {31'h0, schb}, "sched_b pin");
        rd_reg(8'h44, v);
        chk({16'h0, e}, {16'h0, v[15:0]}, "result");
        rd_reg(8'h40, v);
        chk({31'h0, c[1] & s_set}, {31'h0, v[1]}, "sched_b flag");
        e = {15'h0, ((c[1] & s_set) ? c[5] : c[4]) & (!p_set | (l_set < 13'h0400))};
        chk({16'h0, e}, {31'h0, v[2]}, "fallback flag");
    end
    end_of_test;
end
endmodule // test_ita_timing_adjust
